/* File: verilog/scs_sensor_command_sequencer.sv */
`default_nettype none
module scs_sensor_command_sequencer #(
   parameter int UNIT_CYCLES = scs_pkg::INTERVAL_UNIT_CYCLES
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic [5:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output scs_pkg::scs_meas_req_s meas_req,
   input wire scs_pkg::scs_meas_ans_s meas_ans,
   input wire logic [95:0] calib_data,
   output logic [6:0] slave_addr,
   output logic seq_awake
);
   generate
      if (UNIT_CYCLES < 1 || UNIT_CYCLES > 65535) begin : g_bad_unit
         $error("UNIT_CYCLES out of range");
      end
   endgenerate

   typedef enum logic [2:0] {ST_SLEEP, ST_EXEC, ST_SCAN, ST_WAIT} scs_state_e;

   scs_state_e state;
   scs_state_e next_state;
   logic [7:0] cmd_reg;
   logic cmd_pending;
   logic [7:0] cur_cmd;
   logic [7:0] write_mailbox;
   logic [7:0] read_mailbox;
   logic [7:0] response;
   logic [7:0] settings [scs_pkg::NUM_SETTINGS];
   logic [15:0] results [scs_pkg::NUM_CH];
   logic [7:0] cal_regs [scs_pkg::CAL_BYTES];
   logic [5:0] scan_mask;
   logic [2:0] cur_ch;
   logic periodic;
   logic prox_auto;
   logic amb_auto;
   logic rate_due;
   logic [15:0] unit_cnt;
   logic [15:0] interval_cnt;
   logic [15:0] wakeup_interval;
   logic [7:0] channel_select_list;
   logic [5:0] auto_mask;
   logic [4:0] cur_idx;
   logic exec;
   logic is_query;
   logic is_store;
   logic store_invalid;
   logic is_nop;
   logic is_reset;
   logic is_addr;
   logic is_force;
   logic is_suspend;
   logic is_start;
   logic is_cal;
   logic scan_end;
   logic ok_done;
   logic meas_ovf;
   logic [5:0] force_mask;
   logic [2:0] first_ch;
   logic [7:0] next_rdata;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);

   // ****************************************************************
   // Command decode.
   // ****************************************************************
   assign wakeup_interval = {settings[scs_pkg::SET_WAKEUP_INTERVAL_HI],
                             settings[scs_pkg::SET_WAKEUP_INTERVAL_LO]};
   assign channel_select_list = settings[scs_pkg::SET_CHANNEL_SELECT_LIST];
   assign auto_mask = {prox_auto ? 3'h0 : 3'h0, 3'h0} |
                      {amb_auto ? channel_select_list[6:4] : 3'h0,
                       prox_auto ? channel_select_list[2:0] : 3'h0};
   assign cur_idx = cur_cmd[4:0];
   assign exec = (state == ST_EXEC);
   assign is_query = exec && (cur_cmd[7:5] == scs_pkg::CMD_SETTINGS_QUERY);
   assign is_store = exec && (cur_cmd[7:5] == scs_pkg::CMD_SETTINGS_STORE);
   assign store_invalid = is_store && (cur_idx == scs_pkg::SET_CHANNEL_SELECT_LIST) &&
                          ((write_mailbox & scs_pkg::CHANNEL_LIST_RESERVED) != 8'h00);
   assign is_nop = exec && (cur_cmd == scs_pkg::CMD_NO_OPERATION);
   assign is_reset = exec && (cur_cmd == scs_pkg::CMD_SOFT_RESET);
   assign is_addr = exec && (cur_cmd == scs_pkg::CMD_SLAVE_ADDRESS_CHANGE);
   assign is_force = exec && (cur_cmd == scs_pkg::CMD_PROXIMITY_SINGLE_SHOT ||
                              cur_cmd == scs_pkg::CMD_AMBIENT_SINGLE_SHOT ||
                              cur_cmd == scs_pkg::CMD_BOTH_GROUPS_SINGLE_SHOT);
   assign is_suspend = exec && (cur_cmd == scs_pkg::CMD_PROXIMITY_SUSPEND ||
                                cur_cmd == scs_pkg::CMD_AMBIENT_SUSPEND ||
                                cur_cmd == scs_pkg::CMD_BOTH_GROUPS_SUSPEND);
   assign is_start = exec && (cur_cmd == scs_pkg::CMD_PROXIMITY_AUTONOMOUS_START ||
                              cur_cmd == scs_pkg::CMD_AMBIENT_AUTONOMOUS_START ||
                              cur_cmd == scs_pkg::CMD_BOTH_GROUPS_AUTONOMOUS_START);
   assign is_cal = exec && (cur_cmd == scs_pkg::CMD_CALIBRATION_FETCH);
   // Single-shot passes select groups from the low two code bits.
   assign force_mask = {cur_cmd[1] ? channel_select_list[6:4] : 3'h0,
                        cur_cmd[0] ? channel_select_list[2:0] : 3'h0};
   assign scan_end = (state == ST_SCAN) && (scan_mask == 6'h00);
   assign meas_ovf = (state == ST_WAIT) && meas_ans.done && meas_ans.overflow;
   assign ok_done = (is_query || (is_store && !store_invalid) || is_suspend || is_start ||
                     (scan_end && !periodic));

   always_comb begin
      first_ch = 3'h0;
      for (int i = scs_pkg::NUM_CH - 1; i >= 0; i--) begin
         if (scan_mask[i]) begin
            first_ch = 3'(i);
         end
      end
   end

   // ****************************************************************
   // Host register port.
   // ****************************************************************
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         cmd_reg <= 8'h00;
         cmd_pending <= 1'b0;
         write_mailbox <= 8'h00;
      end else begin
         if (reg_wr && reg_addr == scs_pkg::REG_COMMAND) begin
            cmd_reg <= reg_wdata;
            cmd_pending <= 1'b1;
         end else if (state == ST_SLEEP) begin
            cmd_pending <= 1'b0;
         end
         if (reg_wr && reg_addr == scs_pkg::REG_WRITE_MAILBOX) begin
            write_mailbox <= reg_wdata;
         end
      end
   end

   always_comb begin
      next_rdata = 8'h00;
      case (reg_addr)
         scs_pkg::REG_COMMAND: next_rdata = cmd_reg;
         scs_pkg::REG_RESPONSE: next_rdata = response;
         scs_pkg::REG_WRITE_MAILBOX: next_rdata = write_mailbox;
         scs_pkg::REG_READ_MAILBOX: next_rdata = read_mailbox;
         scs_pkg::REG_SLAVE_ADDR: next_rdata = {1'b0, slave_addr};
         scs_pkg::REG_SEQ_STATUS: next_rdata = {seq_awake, periodic, 4'h0, amb_auto, prox_auto};
         default: begin
            if (reg_addr >= scs_pkg::REG_RESULT_FIRST && reg_addr <= scs_pkg::REG_RESULT_LAST) begin
               next_rdata = reg_addr[0] ? results[3'((reg_addr - scs_pkg::REG_RESULT_FIRST) >> 1)][15:8]
                                        : results[3'((reg_addr - scs_pkg::REG_RESULT_FIRST) >> 1)][7:0];
            end else if (reg_addr >= scs_pkg::REG_CAL_FIRST && reg_addr <= scs_pkg::REG_CAL_LAST) begin
               next_rdata = cal_regs[4'(reg_addr - scs_pkg::REG_CAL_FIRST)];
            end
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= reg_rd ? next_rdata : 8'h00;
      end
   end

   // ****************************************************************
   // Sequencer state machine.
   // ****************************************************************
   always_comb begin
      next_state = state;
      case (state)
         ST_SLEEP: begin
            if (cmd_pending) begin
               next_state = ST_EXEC;
            end else if (rate_due && auto_mask != 6'h00) begin
               next_state = ST_SCAN;
            end
         end
         ST_EXEC: next_state = is_force ? ST_SCAN : ST_SLEEP;
         ST_SCAN: next_state = (scan_mask == 6'h00) ? ST_SLEEP : ST_WAIT;
         ST_WAIT: next_state = meas_ans.done ? ST_SCAN : ST_WAIT;
         default: next_state = ST_SLEEP;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         state <= ST_SLEEP;
         seq_awake <= 1'b0;
         cur_cmd <= 8'h00;
         scan_mask <= 6'h00;
         cur_ch <= 3'h0;
         periodic <= 1'b0;
         meas_req <= '0;
      end else begin
         state <= next_state;
         seq_awake <= (next_state != ST_SLEEP);
         meas_req.start <= 1'b0;
         case (state)
            ST_SLEEP: begin
               if (cmd_pending) begin
                  cur_cmd <= cmd_reg;
               end else if (rate_due && auto_mask != 6'h00) begin
                  scan_mask <= auto_mask;
                  periodic <= 1'b1;
               end
            end
            ST_EXEC: begin
               if (is_force) begin
                  scan_mask <= force_mask;
                  periodic <= 1'b0;
               end
            end
            ST_SCAN: begin
               if (scan_mask != 6'h00) begin
                  cur_ch <= first_ch;
                  scan_mask[first_ch] <= 1'b0;
                  meas_req.start <= 1'b1;
                  meas_req.chan <= first_ch;
               end
            end
            default: begin
            end
         endcase
      end
   end

   // ****************************************************************
   // Response register.
   // ****************************************************************
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         response <= 8'h00;
      end else if (is_nop || is_reset) begin
         response <= 8'h00;
      end else if (store_invalid) begin
         response <= scs_pkg::RESP_INVALID_SETTING;
      end else if (meas_ovf) begin
         response <= scs_pkg::RESP_OVERFLOW_BASE + {5'h00, cur_ch} +
                     ((cur_ch >= 3'h3) ? 8'h01 : 8'h00);
      end else if (ok_done && response[7:4] == 4'h0) begin
         response <= {4'h0, response[3:0] + 4'h1};
      end
   end

   // ****************************************************************
   // Settings memory and mailboxes.
   // ****************************************************************
   always_ff @(posedge mclk) begin
      if (!rst_b || is_reset) begin
         for (int i = 0; i < scs_pkg::NUM_SETTINGS; i++) begin
            settings[i] <= 8'h00;
         end
         settings[scs_pkg::SET_SLAVE_ADDR] <= {1'b0, scs_pkg::SLAVE_ADDR_RESET};
         read_mailbox <= 8'h00;
      end else if (is_query) begin
         read_mailbox <= settings[cur_idx];
      end else if (is_store && !store_invalid) begin
         settings[cur_idx] <= write_mailbox;
         read_mailbox <= write_mailbox;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         slave_addr <= scs_pkg::SLAVE_ADDR_RESET;
      end else if (is_addr) begin
         slave_addr <= settings[scs_pkg::SET_SLAVE_ADDR][6:0];
      end
   end

   // ****************************************************************
   // Autonomous enables and wakeup timer.
   // ****************************************************************
   always_ff @(posedge mclk) begin
      if (!rst_b || is_reset) begin
         prox_auto <= 1'b0;
         amb_auto <= 1'b0;
      end else if (is_start) begin
         prox_auto <= prox_auto | cur_cmd[0];
         amb_auto <= amb_auto | cur_cmd[1];
      end else if (is_suspend) begin
         prox_auto <= prox_auto & ~cur_cmd[0];
         amb_auto <= amb_auto & ~cur_cmd[1];
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b || wakeup_interval == 16'h0000 || is_start || !(prox_auto || amb_auto)) begin
         unit_cnt <= 16'h0000;
         interval_cnt <= 16'h0000;
         rate_due <= 1'b0;
      end else begin
         if (unit_cnt == 16'(UNIT_CYCLES - 1)) begin
            unit_cnt <= 16'h0000;
            if (interval_cnt == wakeup_interval - 16'h0001) begin
               interval_cnt <= 16'h0000;
               rate_due <= 1'b1;
            end else begin
               interval_cnt <= interval_cnt + 16'h0001;
            end
         end else begin
            unit_cnt <= unit_cnt + 16'h0001;
            if (state == ST_SLEEP && !cmd_pending) begin
               rate_due <= 1'b0;
            end
         end
      end
   end

   // ****************************************************************
   // Result and calibration registers.
   // ****************************************************************
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         for (int i = 0; i < scs_pkg::NUM_CH; i++) begin
            results[i] <= 16'h0000;
         end
      end else if (state == ST_WAIT && meas_ans.done) begin
         results[cur_ch] <= meas_ans.value;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         for (int i = 0; i < scs_pkg::CAL_BYTES; i++) begin
            cal_regs[i] <= 8'h00;
         end
      end else if (is_cal) begin
         for (int i = 0; i < scs_pkg::CAL_BYTES; i++) begin
            cal_regs[i] <= calib_data[i * 8 +: 8];
         end
      end
   end

   // ****************************************************************
   // Checks.
   // ****************************************************************
   AST_QUIET_ACCESS: assert property ((state == ST_SLEEP && !cmd_pending && !rate_due)
      |=> state == ST_SLEEP) else $error("sequencer woke without cause");
   AST_CMD_WAKE: assert property ((state == ST_SLEEP && !cmd_pending && !rate_due && reg_wr &&
      reg_addr == scs_pkg::REG_COMMAND) |-> ##2 state == ST_EXEC)
      else $error("command write did not wake sequencer");
   AST_FORCED_MODE: assert property (wakeup_interval == 16'h0000 |=> !rate_due)
      else $error("periodic wake with zero interval");
   AST_PERIODIC_WAKE: assert property ((state == ST_SLEEP && !cmd_pending && rate_due &&
      auto_mask != 6'h00) |=> state == ST_SCAN && periodic)
      else $error("periodic wake missed");
   AST_AUTO_START: assert property ((exec && cur_cmd == scs_pkg::CMD_BOTH_GROUPS_AUTONOMOUS_START)
      |=> prox_auto && amb_auto) else $error("autonomous start not taken");
   AST_SUSPEND: assert property ((exec && cur_cmd == scs_pkg::CMD_BOTH_GROUPS_SUSPEND)
      |=> !prox_auto && !amb_auto) else $error("suspend not taken");
   AST_ORDER: assert property (meas_req.start |->
      ((scan_mask & ((6'h01 << meas_req.chan) - 6'h01)) == 6'h00))
      else $error("channel run out of order");
   AST_FORCE_PASS: assert property (is_force |=> state == ST_SCAN && scan_mask == $past(force_mask))
      else $error("single shot pass not started");
   AST_RESULT: assert property ((state == ST_WAIT && meas_ans.done) |=>
      results[$past(cur_ch)] == $past(meas_ans.value)) else $error("result not stored");
   AST_COUNT: assert property ((ok_done && response[7:4] == 4'h0 && !store_invalid && !meas_ovf)
      |=> response == {4'h0, $past(response[3:0]) + 4'h1}) else $error("counter not bumped");
   AST_NOP: assert property (is_nop |=> response == 8'h00) else $error("no-op left response");
   AST_STICKY: assert property ((response[7:4] != 4'h0 && !is_nop && !is_reset &&
      !store_invalid && !meas_ovf) |=> response == $past(response))
      else $error("error code lost");
   AST_QUERY: assert property (is_query |=> read_mailbox == $past(settings[cur_idx]))
      else $error("query mailbox wrong");
   AST_STORE: assert property ((is_store && !store_invalid) |=> read_mailbox == $past(write_mailbox)
      && settings[$past(cur_idx)] == $past(write_mailbox)) else $error("store wrong");
   AST_ADDR: assert property (is_addr |=> response == $past(response) &&
      slave_addr == $past(settings[scs_pkg::SET_SLAVE_ADDR][6:0]))
      else $error("address change wrong");
   AST_RESERVED: assert property ((exec && !is_query && !is_store && !is_force) |=>
      state == ST_SLEEP && !meas_req.start) else $error("reserved code measured");
endmodule // scs_sensor_command_sequencer
`default_nettype wire

/* File: verilog/scs_pkg.sv */
`default_nettype none
package scs_pkg;
   // ****************************************************************
   // Register map.
   // ****************************************************************
   localparam int ADDR_W = 6;
   localparam int DATA_W = 8;
   localparam logic [5:0] REG_COMMAND = 6'h00;
   localparam logic [5:0] REG_RESPONSE = 6'h01;
   localparam logic [5:0] REG_WRITE_MAILBOX = 6'h02;
   localparam logic [5:0] REG_READ_MAILBOX = 6'h03;
   localparam logic [5:0] REG_SLAVE_ADDR = 6'h04;
   localparam logic [5:0] REG_SEQ_STATUS = 6'h05;
   localparam logic [5:0] REG_RESULT_FIRST = 6'h10;
   localparam logic [5:0] REG_RESULT_LAST = 6'h1B;
   localparam logic [5:0] REG_CAL_FIRST = 6'h22;
   localparam logic [5:0] REG_CAL_LAST = 6'h2D;
   localparam int NUM_CH = 6;
   localparam int CAL_BYTES = 12;
   // ****************************************************************
   // Command codes and response codes.
   // ****************************************************************
   localparam logic [7:0] CMD_NO_OPERATION = 8'h00;
   localparam logic [7:0] CMD_SOFT_RESET = 8'h01;
   localparam logic [7:0] CMD_SLAVE_ADDRESS_CHANGE = 8'h02;
   localparam logic [7:0] CMD_PROXIMITY_SINGLE_SHOT = 8'h05;
   localparam logic [7:0] CMD_AMBIENT_SINGLE_SHOT = 8'h06;
   localparam logic [7:0] CMD_BOTH_GROUPS_SINGLE_SHOT = 8'h07;
   localparam logic [7:0] CMD_PROXIMITY_SUSPEND = 8'h09;
   localparam logic [7:0] CMD_AMBIENT_SUSPEND = 8'h0A;
   localparam logic [7:0] CMD_BOTH_GROUPS_SUSPEND = 8'h0B;
   localparam logic [7:0] CMD_PROXIMITY_AUTONOMOUS_START = 8'h0D;
   localparam logic [7:0] CMD_AMBIENT_AUTONOMOUS_START = 8'h0E;
   localparam logic [7:0] CMD_BOTH_GROUPS_AUTONOMOUS_START = 8'h0F;
   localparam logic [7:0] CMD_CALIBRATION_FETCH = 8'h12;
   localparam logic [2:0] CMD_SETTINGS_QUERY = 3'h4;
   localparam logic [2:0] CMD_SETTINGS_STORE = 3'h5;
   localparam logic [7:0] RESP_INVALID_SETTING = 8'h80;
   localparam logic [7:0] RESP_OVERFLOW_BASE = 8'h88;
   // ****************************************************************
   // Settings memory layout and reset values.
   // ****************************************************************
   localparam int NUM_SETTINGS = 32;
   localparam logic [4:0] SET_SLAVE_ADDR = 5'h00;
   localparam logic [4:0] SET_CHANNEL_SELECT_LIST = 5'h01;
   localparam logic [4:0] SET_WAKEUP_INTERVAL_LO = 5'h08;
   localparam logic [4:0] SET_WAKEUP_INTERVAL_HI = 5'h09;
   localparam logic [7:0] CHANNEL_LIST_RESERVED = 8'h88;
   localparam logic [6:0] SLAVE_ADDR_RESET = 7'h2A;
   // ****************************************************************
   // Timing: one wakeup-interval unit.
   // ****************************************************************
   localparam int CLK_PERIOD_NS = 40;
   localparam int INTERVAL_UNIT_NS = 31250;
   localparam int INTERVAL_UNIT_CYCLES = INTERVAL_UNIT_NS / CLK_PERIOD_NS;
   // ****************************************************************
   // Carriers to the conversion front end.
   // ****************************************************************
   typedef struct packed {
      logic start;
      logic [2:0] chan;
   } scs_meas_req_s;
   typedef struct packed {
      logic done;
      logic overflow;
      logic [15:0] value;
   } scs_meas_ans_s;
endpackage
`default_nettype wire

/* File: verification/scs_converter_model.sv */
`default_nettype none
module scs_converter_model (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic slow,
   input wire scs_pkg::scs_meas_req_s meas_req,
   output scs_pkg::scs_meas_ans_s meas_ans
);
   timeunit 1ns;
   timeprecision 1ns;
   logic busy;
   logic [2:0] chan;
   logic [3:0] wait_cnt;
   // ****************************************************************
   // One conversion at a time, prompt or slow; the result bus toggles when idle.
   // ****************************************************************
   always_ff @(posedge mclk) begin
      meas_ans.done <= 1'b0;
      meas_ans.overflow <= 1'b0;
      meas_ans.value <= ~meas_ans.value;
      if (!rst_b) begin
         busy <= 1'b0;
         meas_ans.value <= 16'h5A5A;
      end else if (meas_req.start) begin
         busy <= 1'b1;
         chan <= meas_req.chan;
         wait_cnt <= slow ? 4'h9 : 4'h1;
      end else if (busy && wait_cnt == 4'h0) begin
         busy <= 1'b0;
         meas_ans.done <= 1'b1;
         meas_ans.value <= {5'h02, chan, 8'hC3 ^ {5'h00, chan}};
      end else if (busy) begin
         wait_cnt <= wait_cnt - 4'h1;
      end
   end
endmodule // scs_converter_model
`default_nettype wire

/* File: verification/test_sensor_command_sequencer.sv */
`default_nettype none
module test_sensor_command_sequencer;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, slow = 0, rd_d = 0, aw_d = 0, en;
   logic [5:0] reg_addr = '0;
   logic [7:0] reg_wdata = '0, reg_rdata, lfsr = 8'h45, ch, exp_v;
   logic [95:0] calib_data = '0;
   logic [6:0] slave_addr;
   logic [3:0] cnt;
   logic seq_awake;
   scs_pkg::scs_meas_req_s meas_req;
   scs_pkg::scs_meas_ans_s meas_ans;
   logic [7:0] exp_q[$];
   int fail_count = 0, check_count = 0, awake_cnt = 0;
   always #20 mclk = ~mclk;
   scs_sensor_command_sequencer #(.UNIT_CYCLES(4)) dut (.mclk(mclk), .rst_b(rst_b),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .meas_req(meas_req), .meas_ans(meas_ans),
      .calib_data(calib_data), .slave_addr(slave_addr), .seq_awake(seq_awake));
   scs_converter_model conv (.mclk(mclk), .rst_b(rst_b), .slow(slow), .meas_req(meas_req),
      .meas_ans(meas_ans));
   function automatic logic [7:0] nxt(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction
   task automatic chk(input logic ok);
      check_count++;
      if (ok !== 1'b1) begin
         $display("mismatch at %0t: sequencer activity", $time);
         fail_count++;
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic rd(input logic [5:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic cmd(input logic [7:0] c);
      int n;
      wr(6'h00, c);
      for (n = 0; n < 30 && seq_awake !== 1'b1; n++) @(posedge mclk);
      for (n = 0; n < 600 && seq_awake !== 1'b0; n++) @(posedge mclk);
      chk(seq_awake === 1'b0);
   endtask
   task automatic finish_test;
      if (fail_count == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // ****************************************************************
   // Read data is compared one cycle after its strobe.
   // ****************************************************************
   always @(posedge mclk) begin
      aw_d <= seq_awake;
      if (seq_awake === 1'b1 && aw_d === 1'b0) awake_cnt++;
      if (rd_d) begin
         exp_v = exp_q.pop_front();
         check_count++;
         if (reg_rdata !== exp_v) begin
            $display("mismatch at %0t: read %h expected %h", $time, reg_rdata, exp_v);
            fail_count++;
         end
      end
      rd_d <= reg_rd;
   end
   initial begin
      repeat (20000) @(posedge mclk);
      fail_count++;
      finish_test();
   end
   initial begin
      repeat (2) @(posedge mclk);
      rst_b <= 1'b1;
      @(posedge mclk);
      rd(6'h01, 8'h00);
      rd(6'h04, 8'h2A);
      for (int i = 0; i < 12; i++) begin
         lfsr = nxt(lfsr);
         calib_data[8*i +: 8] <= lfsr;
      end
      ch = (nxt(lfsr) & 8'h77) | 8'h11;
      wr(6'h02, ch);
      cmd(8'hA1);
      rd(6'h03, ch);
      rd(6'h01, 8'h01);
      wr(6'h02, 8'h00);
      cmd(8'h81);
      rd(6'h03, ch);
      rd(6'h01, 8'h02);
      chk(seq_awake === 1'b0);
      cmd(8'h07);
      for (int i = 0; i < 6; i++) begin
         en = (i < 3) ? ch[i] : ch[i + 1];
         rd(6'h10 + 6'(2 * i), en ? (8'hC3 ^ 8'(i)) : 8'h00);
         rd(6'h11 + 6'(2 * i), en ? {5'h02, 3'(i)} : 8'h00);
      end
      rd(6'h01, 8'h03);
      cnt = 4'h3;
      slow <= 1'b1;
      for (int k = 0; k < 14; k++) begin
         cmd(8'h05 + 8'(k % 2) + ((k % 4 > 1) ? 8'h04 : 8'h00));
         cnt = cnt + 4'h1;
         rd(6'h01, {4'h0, cnt});
      end
      cmd(8'h03);
      rd(6'h01, {4'h0, cnt});
      wr(6'h02, 8'h08);
      cmd(8'hA1);
      rd(6'h01, 8'h80);
      cmd(8'h06);
      rd(6'h01, 8'h80);
      cmd(8'h00);
      rd(6'h01, 8'h00);
      cmd(8'h12);
      rd(6'h22, calib_data[7:0]);
      rd(6'h2D, calib_data[95:88]);
      awake_cnt = 0;
      repeat (100) @(posedge mclk);
      chk(awake_cnt == 0);
      wr(6'h02, 8'h03);
      cmd(8'hA8);
      cmd(8'h0F);
      rd(6'h01, 8'h02);
      awake_cnt = 0;
      repeat (400) @(posedge mclk);
      chk(awake_cnt >= 3);
      wr(6'h00, 8'h0B);
      repeat (150) @(posedge mclk);
      rd(6'h01, 8'h03);
      awake_cnt = 0;
      repeat (200) @(posedge mclk);
      chk(awake_cnt == 0);
      cmd(8'h01);
      rd(6'h01, 8'h00);
      wr(6'h02, 8'h3C);
      cmd(8'hA0);
      cmd(8'h02);
      chk(slave_addr === 7'h3C);
      rd(6'h04, 8'h3C);
      cmd(8'h81);
      rd(6'h03, 8'h00);
      repeat (3) @(posedge mclk);
      finish_test();
   end
endmodule // test_sensor_command_sequencer
`default_nettype wire
